// *** pkg/adcc_cfg.svh ***
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
`define ADCC_OFF_PORT_A      8'h05
`define ADCC_OFF_PORT_E      8'h09
`define ADCC_OFF_INTCTL      8'h0b
`define ADCC_OFF_PFLAG1      8'h0c
`define ADCC_OFF_RES_HI      8'h1e
`define ADCC_OFF_CTRL_MAIN   8'h1f
`define ADCC_OFF_DIR_A       8'h85
`define ADCC_OFF_DIR_E       8'h89
`define ADCC_OFF_PEN1        8'h8c
`define ADCC_OFF_RES_LO      8'h9e
`define ADCC_OFF_PORT_CFG    8'h9f
`define ADCC_OFF_SLEEP       8'hc0
`define ADCC_RST_CTRL_MAIN   8'h00
`define ADCC_RST_PORT_CFG    8'h00
`define ADCC_RST_DIR_A       8'h3f
`define ADCC_RST_DIR_E       8'h07
`define ADCC_RST_ZERO        8'h00
`define ADCC_CTRL_WMASK      8'hfd
`define ADCC_CFG_WMASK       8'h8f
`define ADCC_DIR_A_WMASK     8'h3f
`define ADCC_DIR_E_WMASK     8'h07
`define ADCC_BIT_POWER       0
`define ADCC_BIT_GO          2
`define ADCC_BIT_DONE_FLAG   6
`define ADCC_BIT_DONE_IE     6
`define ADCC_BIT_PERIPHERAL_IRQ_ENABLE        6
`define ADCC_BIT_GIE         7
`define ADCC_BIT_JUSTIFY     7
`define ADCC_CS_DIV2         2'h0
`define ADCC_CS_DIV8         2'h1
`define ADCC_CS_DIV32        2'h2
`define ADCC_CS_RC           2'h3
`define ADCC_DIV2_CNT        6'h01
`define ADCC_DIV8_CNT        6'h07
`define ADCC_DIV32_CNT       6'h1f
`define ADCC_CONV_BITS       4'hc
`define ADCC_WAIT_BITS       4'h2
`define ADCC_ICYC_TICKS      3'h4
`define ADCC_SAMPLE_MSB      4'h9
`endif

// *** pkg/adcc_pkg.sv ***
// Types of the converter control block
`default_nettype none
package adcc_pkg;
  typedef enum logic [2:0] {
    ADCC_IDLE,
    ADCC_ICYC,
    ADCC_FIRST,
    ADCC_CONV,
    ADCC_HOLDOFF
  } adcc_state_t;
endpackage
`default_nettype wire

// *** sim/adcc_analog_model.sv ***
// Behavioural analog side of the converter: RC clock and comparator
`default_nettype none
module adcc_analog_model
(
  // Bench control
  input  wire logic rc_run_i,
  input  wire logic level_i,
  // Converter side
  input  wire logic sample_hold_i,
  output logic      rc_clk_o,
  output logic      sample_bit_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********************************
  // RC clock and comparator
  // ********************************
  // Period unrelated to the system clock; stands low outside frames
  initial
  begin
    rc_clk_o = 1'b0;
    forever
    begin
      #67.3;
      rc_clk_o = rc_run_i & ~rc_clk_o;
    end
  end
  // While acquiring the decision is meaningless, so show the inverse
  assign sample_bit_o = sample_hold_i ? ~level_i : level_i;
endmodule
`default_nettype wire

// *** sim/adcc_top_test.sv ***
// Self-checking bench of the converter control block
`default_nettype none
module adcc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ********************************
  // Signals, tasks and scenarios
  // ********************************
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic        rd_r;
  logic        wr_r;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        wait_req;
  logic        rc_clk;
  logic        smp;
  logic [5:0]  pa;
  logic [2:0]  pe;
  logic        hold;
  logic [2:0]  chan;
  logic        aen;
  logic        slp;
  logic        wake;
  logic        irq;
  logic        rc_run;
  logic        level;
  logic [31:0] seed;
  logic [15:0] rp;
  logic [7:0]  d;
  logic [7:0]  ctrl;
  int          cyc;
  int          t0;
  int          fail_count;
  int          checks_done;
  logic [15:0] rst_tab [8] = '{16'h1f00, 16'h9f00, 16'h853f, 16'h8907,
                               16'h0b00, 16'h0c00, 16'h8c00, 16'h4000};

  adcc_top i_adcc_top (.sys_clk_i(clk), .reset_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .rc_clk_i(rc_clk),
    .sample_bit_i(smp), .port_a_pins_i(pa), .port_e_pins_i(pe), .sample_hold_o(hold),
    .channel_o(chan), .analog_enable_o(aen), .sleep_i(slp), .wake_o(wake), .irq_o(irq));
  adcc_analog_model i_adcc_analog_model (.rc_run_i(rc_run), .level_i(level),
    .sample_hold_i(hold), .rc_clk_o(rc_clk), .sample_bit_o(smp));

  initial
  begin
    clk = 1'b0;
    forever
      #20 clk = ~clk;
  end
  always @(posedge clk)
    cyc <= cyc + 1;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int div(input logic [1:0] c);
    return 2 << (2 * c);
  endfunction
  function automatic logic [15:0] res(input logic j, input logic l);
    return j ? {6'h00, {10{l}}} : {{10{l}}, 6'h00};
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic timeout;
    fail_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    test_done();
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic wait_ack;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_req !== 1'b0 && n < 50);
    if (n >= 50)
      timeout();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    wr_r <= 1'b1;
    addr <= a;
    wdata <= v;
    wait_ack();
    wr_r <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    rd_r <= 1'b1;
    addr <= a;
    wait_ack();
    v = rdata;
    rd_r <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  task automatic wait_go;
    do
      rd(8'h1f, d);
    while (d[2] !== 1'b0 && cyc - t0 < 3000);
    if (cyc - t0 >= 3000)
      timeout();
  endtask
  // Acquisition resumes only after the holdoff, so go is set once idle
  task automatic wait_idle;
    int n;
    n = 0;
    while (hold !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
      timeout();
  endtask
  task automatic pair_chk;
    rchk(8'h1e, rp[15:8]);
    rchk(8'h9e, rp[7:0]);
  endtask

  initial
  begin
    {addr, rd_r, wr_r, wdata, pa, pe, slp, rc_run, level} = '0;
    {cyc, fail_count, checks_done} = '0;
    seed = 32'hc90c_c99f;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rst_tab[k])
      rchk(rst_tab[k][15:8], rst_tab[k][7:0]);
    rp = 16'(rnd());
    wr(8'h1e, rp[15:8]);
    wr(8'h9e, rp[7:0]);
    pair_chk();
    wr(8'h1f, 8'h3e);
    rchk(8'h1f, 8'h38);
    $display("registers done");
    for (int i = 0; i < 6; i++)
    begin
      level <= 1'(rnd());
      wr(8'h9f, {i[0], 7'h00});
      wr(8'h85, 8'(rnd()) & 8'h3f);
      ctrl = {i[1:0] % 2'h3, 3'(rnd()), 3'b001};
      wr(8'h1f, ctrl);
      chk({5'h00, chan}, {5'h00, ctrl[5:3]});
      wait_idle();
      t0 = cyc;
      wr(8'h1f, ctrl | 8'h04);
      wait_go();
      chk({7'h00, cyc - t0 >= 12 * div(ctrl[7:6])}, 8'h01);
      chk({7'h00, cyc - t0 <= 13 * div(ctrl[7:6]) + 12}, 8'h01);
      rp = res(i[0], level);
      pair_chk();
      rchk(8'h0c, 8'h40);
      wr(8'h8c, 8'h40);
      wr(8'h0b, 8'hc0);
      chk({7'h00, irq}, 8'h01);
      wr(8'h0c, 8'h00);
      chk({7'h00, irq}, 8'h00);
    end
    $display("conversions done");
    wait_idle();
    wr(8'h1f, 8'h85);
    repeat (40) @(posedge clk);
    wr(8'h1f, 8'h81);
    pair_chk();
    rchk(8'h0c, 8'h00);
    slp <= 1'b0;
    wait_idle();
    wr(8'h1f, 8'h85);
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h00, aen}, 8'h00);
    rd(8'h1f, d);
    chk({7'h00, d[0]}, 8'h01);
    chk({7'h00, d[2]}, 8'h00);
    slp <= 1'b0;
    wr(8'h1f, 8'h81);
    pair_chk();
    $display("aborts done");
    level <= ~level;
    wr(8'h0b, 8'h00);
    wr(8'h1f, 8'hc1);
    rc_run <= 1'b1;
    wait_idle();
    wr(8'h1f, 8'hc5);
    wr(8'hc0, 8'h01);
    t0 = cyc;
    while (wake !== 1'b1 && cyc - t0 < 3000)
      @(posedge clk);
    chk({7'h00, wake}, 8'h01);
    rc_run <= 1'b0;
    rchk(8'h1f, 8'hc1);
    rp = res(1'b1, level);
    pair_chk();
    $display("sleep done");
    wr(8'h1f, 8'h81);
    wait_idle();
    wr(8'h1f, 8'h85);
    repeat (10) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({7'h00, aen}, 8'h00);
    rchk(8'h1f, 8'h00);
    pair_chk();
    pa <= 6'h3f;
    pe <= 3'h7;
    repeat (4) @(posedge clk);
    rchk(8'h05, 8'h10);
    rchk(8'h09, 8'h00);
    wr(8'h9f, 8'h06);
    rchk(8'h05, 8'h3f);
    rchk(8'h09, 8'h07);
    $display("reset and ports done");
    test_done();
  end
endmodule
`default_nettype wire

// *** src/adcc_top.sv ***
// Converter control: clock select, go handshake, result pair, sleep and port gating
//
// Contract
// R1: A conversion takes twelve bit periods from effective start to done.
// R2: Clock select 00/01/10/11 gives 2, 8, 32 oscillator periods or RC clock.
// R3: Software picks a setting giving at least 1.6 us bit period.
// R4: Above 1 MHz software uses the RC clock only for sleep conversions.
// R5: An analog pin set as output is still converted from its driven level.
// R6: Channel select and direction bits never gate a conversion.
// R7: Port reads return zero on every pin configured as analog.
// R8: Clearing go mid-conversion aborts; result pair stays unchanged.
// R9: After abort wait two bit periods, then acquisition resumes.
// R10: First segment after go lasts one instruction cycle up to one bit period.
// R11: Software never sets go in the write that powers the converter on.
// R12: Result placed left or right justified, six unused bits zero.
// R13: With converter off the result bytes are plain read-write storage.
// R14: RC clock delays one instruction cycle after go before converting.
// R15: RC conversion done in sleep clears go, loads result, wakes if enabled.
// R16: Sleep with non-RC clock aborts and powers down; power bit stays set.
// R17: For sleep conversions software selects RC and sleeps right after go.
// R18: Reset restores registers, powers off, aborts, sets all pins analog; the reset pin map leaves port A bit 4 digital.
// R19: Result pair is not touched by reset.
// R20: Completion loads result, clears go, sets done flag, may request interrupt.
// R21: After completion wait two bit periods before new acquisition.
// R22: Go writes are ignored while the converter is powered off.
// R23: Go and clock select sampled on device clock; RC ticks synchronised in.
`include "adcc_cfg.svh"
`default_nettype none
module adcc_top
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [7:0]  avs_writedata_i,
  output logic      [7:0]  avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Analog side
  input  wire logic        rc_clk_i,
  input  wire logic        sample_bit_i,
  input  wire logic [5:0]  port_a_pins_i,
  input  wire logic [2:0]  port_e_pins_i,
  output logic             sample_hold_o,
  output logic [2:0]       channel_o,
  output logic             analog_enable_o,
  // System
  input  wire logic        sleep_i,
  output logic             wake_o,
  output logic             irq_o
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0]  ctrl_main;
  logic [7:0]  port_cfg;
  logic [7:0]  dir_a;
  logic [7:0]  dir_e;
  logic [7:0]  intctl;
  logic [7:0]  pflag1;
  logic [7:0]  pen1;
  logic [7:0]  res_hi;
  logic [7:0]  res_lo;
  logic        sleep_reg;
  logic        rd_pending;
  adcc_pkg::adcc_state_t state;
  adcc_pkg::adcc_state_t next_state;
  logic [5:0]  div_cnt;
  logic [3:0]  bit_cnt;
  logic [2:0]  icyc_cnt;
  logic [9:0]  shift;
  logic [2:0]  rc_sync;
  logic [5:0]  pa_s1;
  logic [5:0]  pa_s2;
  logic [2:0]  pe_s1;
  logic [2:0]  pe_s2;
  logic        smp_s1;
  logic        smp_s2;

  wire acc_wr = avs_write_i;
  wire sel_ctrl  = avs_address_i == `ADCC_OFF_CTRL_MAIN;
  wire sel_cfg   = avs_address_i == `ADCC_OFF_PORT_CFG;
  wire sel_res_h = avs_address_i == `ADCC_OFF_RES_HI;
  wire sel_res_l = avs_address_i == `ADCC_OFF_RES_LO;
  wire sel_pf1   = avs_address_i == `ADCC_OFF_PFLAG1;
  wire sel_pen1  = avs_address_i == `ADCC_OFF_PEN1;
  wire sel_int   = avs_address_i == `ADCC_OFF_INTCTL;
  wire sel_dir_a = avs_address_i == `ADCC_OFF_DIR_A;
  wire sel_dir_e = avs_address_i == `ADCC_OFF_DIR_E;
  wire sel_pa    = avs_address_i == `ADCC_OFF_PORT_A;
  wire sel_pe    = avs_address_i == `ADCC_OFF_PORT_E;
  wire sel_slp   = avs_address_i == `ADCC_OFF_SLEEP;

  wire [1:0] clk_sel   = ctrl_main[7:6];
  wire       power_on  = ctrl_main[`ADCC_BIT_POWER];
  wire       go_bit    = ctrl_main[`ADCC_BIT_GO];
  wire       is_rc     = clk_sel == `ADCC_CS_RC;
  wire       asleep    = sleep_i | sleep_reg;
  // Module is powered down in sleep with non-RC clock although the bit reads set
  wire       active    = power_on & ~(asleep & ~is_rc); // R16
  wire       busy      = (state == adcc_pkg::ADCC_ICYC) | (state == adcc_pkg::ADCC_FIRST)
                       | (state == adcc_pkg::ADCC_CONV);

  // ****************************************************************
  // Bit period tick
  // ****************************************************************
  wire [5:0] div_top = (clk_sel == `ADCC_CS_DIV2) ? `ADCC_DIV2_CNT :
                       (clk_sel == `ADCC_CS_DIV8) ? `ADCC_DIV8_CNT : `ADCC_DIV32_CNT; // R2
  wire rc_tick  = rc_sync[1] & ~rc_sync[2]; // R23
  wire osc_tick = div_cnt == div_top;
  wire tad_tick = is_rc ? rc_tick : osc_tick; // R2

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      div_cnt <= 6'h00;
    else
      // Restart on every state change so each wait spans whole bit periods
      div_cnt <= (osc_tick | (next_state != state) | (state == adcc_pkg::ADCC_IDLE))
               ? 6'h00 : div_cnt + 6'h01; // R9 R21
  end

  // RC clock is asynchronous; only the second and third stages are looked at
  always_ff @(posedge sys_clk_i)
  begin
    rc_sync <= {rc_sync[1:0], rc_clk_i}; // R23
    pa_s1   <= port_a_pins_i;
    pa_s2   <= pa_s1;
    pe_s1   <= port_e_pins_i;
    pe_s2   <= pe_s1;
    smp_s1  <= sample_bit_i;
    smp_s2  <= smp_s1;
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  wire go_set   = acc_wr & sel_ctrl & avs_writedata_i[`ADCC_BIT_GO] & power_on & active; // R22
  wire go_clr   = acc_wr & sel_ctrl & ~avs_writedata_i[`ADCC_BIT_GO];
  // Go set during holdoff stays pending and starts the conversion once idle
  wire go_start = go_set | (go_bit & ~go_clr & active); // R9
  wire abort    = busy & (go_clr | ~active); // R8 R16
  wire last_bit = (state == adcc_pkg::ADCC_CONV) & tad_tick
                & (bit_cnt == `ADCC_CONV_BITS - 4'h1); // R1
  wire icyc_end = icyc_cnt == `ADCC_ICYC_TICKS - 3'h1;
  wire hold_end = (state == adcc_pkg::ADCC_HOLDOFF) & tad_tick
                & (bit_cnt == `ADCC_WAIT_BITS - 4'h1); // R9 R21

  always_comb
  begin
    next_state = state;
    case (state)
      adcc_pkg::ADCC_IDLE:    if (go_start) next_state = is_rc ? adcc_pkg::ADCC_ICYC
                                                           : adcc_pkg::ADCC_FIRST; // R14
      adcc_pkg::ADCC_ICYC:    if (icyc_end) next_state = adcc_pkg::ADCC_FIRST; // R14
      adcc_pkg::ADCC_FIRST:   if (tad_tick) next_state = adcc_pkg::ADCC_CONV; // R10
      adcc_pkg::ADCC_CONV:    if (last_bit) next_state = adcc_pkg::ADCC_HOLDOFF;
      adcc_pkg::ADCC_HOLDOFF: if (hold_end) next_state = adcc_pkg::ADCC_IDLE;
      default:                next_state = adcc_pkg::ADCC_IDLE;
    endcase
    if (abort)
      next_state = adcc_pkg::ADCC_HOLDOFF; // R9
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      state    <= adcc_pkg::ADCC_IDLE; // R18
      bit_cnt  <= 4'h0;
      icyc_cnt <= 3'h0;
      shift    <= 10'h000;
    end
    else
    begin
      state    <= next_state;
      icyc_cnt <= (state == adcc_pkg::ADCC_ICYC) ? icyc_cnt + 3'h1 : 3'h0;
      if (next_state != state)
        bit_cnt <= 4'h0;
      else if (tad_tick)
        bit_cnt <= bit_cnt + 4'h1;
      // Comparator bit is sampled whatever direction the pin has
      if (state == adcc_pkg::ADCC_CONV && tad_tick && bit_cnt <= `ADCC_SAMPLE_MSB)
        shift <= {shift[8:0], smp_s2}; // R5 R6
    end
  end

  wire [15:0] result = port_cfg[`ADCC_BIT_JUSTIFY] ? {6'h00, shift}
                                                  : {shift, 6'h00}; // R12
  wire res_load = last_bit & ~abort;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  wire [7:0] ctrl_wval = (avs_writedata_i & `ADCC_CTRL_WMASK)
                       & ~(8'h01 << `ADCC_BIT_GO);
  wire       go_keep   = go_set | (go_bit & ~go_clr & busy);
  wire       go_next   = ~(res_load | abort) & go_keep; // R8 R15 R20

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_main <= `ADCC_RST_CTRL_MAIN; // R18
      port_cfg  <= `ADCC_RST_PORT_CFG; // R18
      dir_a     <= `ADCC_RST_DIR_A;
      dir_e     <= `ADCC_RST_DIR_E;
      intctl    <= `ADCC_RST_ZERO;
      pflag1    <= `ADCC_RST_ZERO;
      pen1      <= `ADCC_RST_ZERO;
      sleep_reg <= 1'b0;
    end
    else
    begin
      if (acc_wr & sel_ctrl)
        ctrl_main <= ctrl_wval | {5'h00, go_next, 2'h0};
      else
        ctrl_main[`ADCC_BIT_GO] <= go_bit & ~res_load & ~abort; // R15 R20
      if (acc_wr & sel_cfg)
        port_cfg <= avs_writedata_i & `ADCC_CFG_WMASK;
      if (acc_wr & sel_dir_a)
        dir_a <= avs_writedata_i & `ADCC_DIR_A_WMASK;
      if (acc_wr & sel_dir_e)
        dir_e <= (dir_e & ~`ADCC_DIR_E_WMASK) | (avs_writedata_i & `ADCC_DIR_E_WMASK);
      if (acc_wr & sel_int)
        intctl <= avs_writedata_i;
      if (acc_wr & sel_pen1)
        pen1 <= avs_writedata_i;
      // Done set wins over a same-cycle software clear
      if (acc_wr & sel_pf1)
        pflag1 <= avs_writedata_i | {1'b0, res_load, 6'h00}; // R20
      else if (res_load)
        pflag1[`ADCC_BIT_DONE_FLAG] <= 1'b1; // R20
      if (acc_wr & sel_slp)
        sleep_reg <= avs_writedata_i[0];
      else if (wake_o)
        sleep_reg <= 1'b0;
    end
  end

  // Result bytes have no reset; hardware load wins over software write
  always_ff @(posedge sys_clk_i)
  begin
    if (res_load)
    begin
      res_hi <= result[15:8]; // R12 R19
      res_lo <= result[7:0];
    end
    else
    begin
      if (acc_wr & sel_res_h)
        res_hi <= avs_writedata_i; // R13
      if (acc_wr & sel_res_l)
        res_lo <= avs_writedata_i; // R13
    end
  end

  // ****************************************************************
  // Port gating and read path
  // ****************************************************************
  // Reduced pin map: config 0 makes all but port A bit 4 analog, 6 or 7 makes all digital
  wire all_dig = port_cfg[3:1] == 3'h3;
  wire [5:0] pa_analog = all_dig ? 6'h00 : (port_cfg[3:0] == 4'h0 ? 6'h2f : 6'h0f);
  wire [2:0] pe_analog = (port_cfg[3:0] == 4'h0) ? 3'h7 : 3'h0;
  wire [7:0] pa_read = {2'h0, pa_s2 & ~pa_analog}; // R7
  wire [7:0] pe_read = {5'h00, pe_s2 & ~pe_analog}; // R7

  wire [7:0] rd_mux =
      sel_ctrl  ? ctrl_main : sel_cfg ? port_cfg : sel_res_h ? res_hi :
      sel_res_l ? res_lo : sel_pf1 ? pflag1 : sel_pen1 ? pen1 :
      sel_int   ? intctl : sel_dir_a ? dir_a : sel_dir_e ? dir_e :
      sel_pa    ? pa_read : sel_pe ? pe_read : sel_slp ? {7'h00, sleep_reg} : 8'h00;

  // Reads take one wait cycle so read data always comes from a flop
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      rd_pending     <= 1'b0;
      avs_readdata_o <= 8'h00;
    end
    else
    begin
      rd_pending <= avs_read_i & ~rd_pending;
      if (avs_read_i & ~rd_pending)
        avs_readdata_o <= rd_mux;
    end
  end

  assign avs_waitrequest_o = avs_read_i & ~rd_pending;

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire done_irq = pflag1[`ADCC_BIT_DONE_FLAG] & pen1[`ADCC_BIT_DONE_IE];
  assign irq_o           = done_irq & intctl[`ADCC_BIT_PERIPHERAL_IRQ_ENABLE] & intctl[`ADCC_BIT_GIE]; // R20
  assign wake_o          = asleep & done_irq; // R15
  assign sample_hold_o   = (state == adcc_pkg::ADCC_IDLE) & active; // R21
  assign channel_o       = ctrl_main[5:3];
  assign analog_enable_o = active;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence go_taken_s;
    go_set && state == adcc_pkg::ADCC_IDLE;
  endsequence

  // Shortest oscillator bit period is two clocks
  sequence first_seg_s;
    state == adcc_pkg::ADCC_FIRST [*2];
  endsequence

  done_clears_go_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R20
    res_load |=> !go_bit && pflag1[`ADCC_BIT_DONE_FLAG])
    else $error("done did not clear go or set flag");
  abort_keeps_res_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R8
    abort && !(acc_wr && (sel_res_h || sel_res_l)) |=> $stable(res_hi) && $stable(res_lo))
    else $error("abort changed result");
  abort_holdoff_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R9
    abort |=> state == adcc_pkg::ADCC_HOLDOFF)
    else $error("abort did not enter holdoff");
  rc_delay_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R14
    go_taken_s and is_rc |=> state == adcc_pkg::ADCC_ICYC [*4])
    else $error("rc start not delayed");
  off_no_go_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R22
    !power_on && state == adcc_pkg::ADCC_IDLE |=> state == adcc_pkg::ADCC_IDLE)
    else $error("conversion started while off");
  sleep_abort_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R16
    busy && asleep && !is_rc |=> !busy)
    else $error("non rc sleep did not abort");
  just_zero_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R12
    res_load && port_cfg[`ADCC_BIT_JUSTIFY] |=> res_hi[7:2] == 6'h00)
    else $error("right justify high bits not zero");
  analog_read_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R7
    (pa_read[5:0] & pa_analog) == 6'h00)
    else $error("analog pin read nonzero");
  hold_after_done_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R21
    res_load |=> !sample_hold_o [*2])
    else $error("acquisition restarted too soon");
  osc_first_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R10
    go_taken_s and !is_rc |=> first_seg_s)
    else $error("oscillator start skipped first segment");
  left_zero_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R12
    res_load && !port_cfg[`ADCC_BIT_JUSTIFY] |=> res_lo[5:0] == 6'h00)
    else $error("left justify low bits not zero");
  off_storage_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R13
    !power_on && acc_wr && sel_res_h |=> res_hi == $past(avs_writedata_i))
    else $error("result byte not plain storage while off");
  idle_go_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R9
    state == adcc_pkg::ADCC_IDLE && go_bit && !go_clr && active |=> busy)
    else $error("pending go did not start");
  sleep_power_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R16
    asleep && !is_rc && power_on && !(acc_wr && sel_ctrl) |=> power_on)
    else $error("power bit lost in sleep");
  done_irq_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R20
    res_load && pen1[`ADCC_BIT_DONE_IE] && intctl[`ADCC_BIT_PERIPHERAL_IRQ_ENABLE] && intctl[`ADCC_BIT_GIE]
    && !(acc_wr && (sel_pf1 || sel_pen1 || sel_int)) |=> irq_o)
    else $error("done did not raise interrupt");
  sleep_wake_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R15
    res_load && sleep_reg && is_rc && pen1[`ADCC_BIT_DONE_IE]
    && !(acc_wr && (sel_slp || sel_pen1)) |=> wake_o)
    else $error("rc done in sleep did not wake");
  // No disable here: the check is about what reset itself leaves behind
  reset_off_a: assert property (@(posedge sys_clk_i) // R18
    !reset_n_i |=> !analog_enable_o && state == adcc_pkg::ADCC_IDLE)
    else $error("reset left converter running");

endmodule
`default_nettype wire
